// file: hdl/ahs_homing_seq.sv
`timescale 1ns/10ps
// Notes on behaviour
// R1 - a dog homing starts toward the dog at the homing rapid rate
// R2 - dog seen in rapid: ramp to stop, then step to approach speed
// R3 - after dog release, stop at first valid grid point: electrical zero
// R4 - first homing is dog type; later ones may use high-speed return
// R5 - high-speed return goes straight to stored reference at general rapid
// R6 - a non-homing move before any homing is refused with an error pulse
// R7 - grid points come from the encoder index pulse
// R8 - further grid points repeat at the configured grid spacing
// R9 - grid points within the mask distance after dog release are ignored
// R10 - grid amount is release (or mask end) to electrical zero distance
// R11 - reference is electrical zero plus shift in homing direction
// R12 - after deceleration, direction setting 0 is positive, 1 negative
// R13 - no-reference setting 1 skips homing and allows motion
// R14 - after homing, machine position puts reference at the zero offset
// R15 - approach speed is applied as a step, no ramp
// R16 - homing rapid rate applies to manual and automatic homing alike
// R17 - the user picks a mask giving about half a grid space amount
// R18 - grid spacing 0 means the screw pitch is used
// R19 - homed flag clears at reset, sets when stopped at reference
module ahs_homing_seq
	import ahs_pkg::*;
(
	input  wire logic                      ref_clk_i,
	input  wire logic                      rst_b_i,
	input  wire ahs_pkg::ahs_cfg_t         cfg_i,
	input  wire logic                      cmd_valid_i,
	input  wire ahs_pkg::ahs_cmd_t         cmd_i,
	output logic                           cmd_ready_o,
	input  wire logic                      dog_i,
	input  wire logic                      index_i,
	input  wire logic signed [POS_W-1:0]   pos_i,
	output logic signed [SPD_W:0]          speed_o,
	output logic                           not_homed_motion_error_o,
	output ahs_pkg::ahs_stat_t             stat_o
);
	import ahs_pkg::*;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_RAPID,
		ST_DECEL,
		ST_APPROACH,
		ST_MASK,
		ST_SEEK,
		ST_SHIFT,
		ST_POSN
	} ahs_state_t;

	ahs_state_t              state_r;
	logic signed [POS_W-1:0] mark_r;
	logic signed [POS_W-1:0] tgt_r;
	logic signed [POS_W-1:0] ref_pos_r;
	logic        [POS_W-1:0] grid_amount_r;
	logic signed [POS_W-1:0] machine_pos_r;
	logic                    homed_r;
	logic                    home_move_r;
	logic                    posn_neg_r;
	logic                    err_r;
	logic signed [SPD_W:0]   spd_target;
	logic                    spd_jump;
	logic                    grid_pt;
	logic        [POS_W-1:0] trav_w;
	logic                    take;
	logic                    take_home;
	logic                    take_move;
	logic                    reached;
	logic                    home_done;

	// magnitude plus direction to a signed speed
	function automatic logic signed [SPD_W:0] sgn_spd(input logic [SPD_W-1:0] mag, input logic neg);
		sgn_spd = neg ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
	endfunction

	// ============================================================
	// submodules
	ahs_grid #(
		.W (POS_W)
	) u_grid (
		.ref_clk_i     (ref_clk_i),
		.rst_b_i       (rst_b_i),
		.index_i       (index_i),
		.pos_i         (pos_i),
		.grid_space_i  (cfg_i.grid_space),
		.screw_pitch_i (cfg_i.screw_pitch),
		.grid_o        (grid_pt)
	);

	ahs_ramp #(
		.W (SPD_W + 1)
	) u_ramp (
		.ref_clk_i (ref_clk_i),
		.rst_b_i   (rst_b_i),
		.target_i  (spd_target),
		.step_i    (cfg_i.decel_step),
		.jump_i    (spd_jump),
		.speed_o   (speed_o)
	);

	// ============================================================
	// handshake and decode
	assign cmd_ready_o = (state_r == ST_IDLE);
	assign take        = cmd_valid_i && cmd_ready_o;
	assign take_home   = take && cmd_i.kind == AHS_CMD_HOME;
	assign take_move   = take && cmd_i.kind == AHS_CMD_MOVE;
	assign trav_w      = (pos_i >= mark_r) ? POS_W'(pos_i - mark_r) : POS_W'(mark_r - pos_i);
	assign reached     = posn_neg_r ? (pos_i <= tgt_r) : (pos_i >= tgt_r);
	assign home_done   = (state_r == ST_SEEK && grid_pt && cfg_i.home_shift_amount == '0) ||
	                     (state_r == ST_SHIFT && trav_w >= cfg_i.home_shift_amount);

	// ============================================================
	// speed target per phase; search phases and idle step, the rest ramp
	always_comb begin
		spd_jump = 1'b0;
		case (state_r)
			ST_RAPID: begin
				spd_target = sgn_spd(cfg_i.homing_rapid_rate, cfg_i.dir_neg); // R1 R16
			end
			ST_DECEL: begin
				spd_target = AHS_SPD_RST; // R2
			end
			ST_APPROACH, ST_MASK, ST_SEEK, ST_SHIFT: begin
				spd_target = sgn_spd(cfg_i.homing_approach_speed, cfg_i.dir_neg); // R12
				spd_jump   = 1'b1; // R15
			end
			ST_POSN: begin
				spd_target = sgn_spd(cfg_i.rapid_rate, posn_neg_r); // R5
			end
			default: begin
				spd_target = AHS_SPD_RST;
				spd_jump   = 1'b1; // hard stop when idle: a homing without shift stops a few approach steps past the grid point
			end
		endcase
	end

	// ============================================================
	// sequencer; positioning has no braking zone, so the axis may overrun
	// by what it travels in the stopping cycles
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			state_r     <= ST_IDLE;
			mark_r      <= AHS_POS_RST;
			tgt_r       <= AHS_POS_RST;
			home_move_r <= 1'b0;
			posn_neg_r  <= AHS_DIR_POS;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (take_home && !cfg_i.noref) begin // R13
						if (homed_r && cfg_i.hs_return_en) begin // R4
							state_r     <= ST_POSN; // R5
							tgt_r       <= ref_pos_r;
							posn_neg_r  <= (ref_pos_r < pos_i);
							home_move_r <= 1'b1;
						end else begin
							state_r <= ST_RAPID; // R1 R4
						end
					end else if (take_move && (homed_r || cfg_i.noref)) begin // R6 R13
						state_r     <= ST_POSN;
						tgt_r       <= $signed(cmd_i.target);
						posn_neg_r  <= ($signed(cmd_i.target) < pos_i);
						home_move_r <= 1'b0;
					end
				end
				ST_RAPID: begin
					if (dog_i) begin
						state_r <= ST_DECEL; // R2
					end
				end
				ST_DECEL: begin
					if (speed_o == AHS_SPD_RST) begin
						state_r <= ST_APPROACH; // R2
					end
				end
				ST_APPROACH: begin
					if (!dog_i) begin
						mark_r  <= pos_i;
						state_r <= (cfg_i.grid_mask == '0) ? ST_SEEK : ST_MASK; // R9
					end
				end
				ST_MASK: begin
					if (trav_w >= cfg_i.grid_mask) begin
						mark_r  <= pos_i; // R10
						state_r <= ST_SEEK; // R9
					end
				end
				ST_SEEK: begin
					if (grid_pt) begin
						mark_r  <= pos_i;
						state_r <= (cfg_i.home_shift_amount == '0) ? ST_IDLE : ST_SHIFT; // R3 R11
					end
				end
				ST_SHIFT: begin
					if (home_done) begin
						state_r <= ST_IDLE; // R11
					end
				end
				ST_POSN: begin
					if (reached) begin
						state_r <= ST_IDLE;
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// ============================================================
	// reference point and grid amount captured at the electrical zero
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			ref_pos_r     <= AHS_POS_RST;
			grid_amount_r <= AHS_POS_RST;
		end else if (state_r == ST_SEEK && grid_pt) begin
			grid_amount_r <= trav_w; // R10
			if (cfg_i.dir_neg == AHS_DIR_NEG) begin
				ref_pos_r <= pos_i - $signed(cfg_i.home_shift_amount); // R11
			end else begin
				ref_pos_r <= pos_i + $signed(cfg_i.home_shift_amount); // R11
			end
		end
	end

	// ============================================================
	// homed flag: only reset clears it
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			homed_r <= 1'b0; // R19
		end else if (home_done) begin
			homed_r <= 1'b1; // R19
		end
	end

	// ============================================================
	// refused motion before homing gives a one-cycle error pulse
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			err_r <= 1'b0;
		end else begin
			err_r <= take_move && !homed_r && !cfg_i.noref; // R6
		end
	end

	// ============================================================
	// machine coordinate; before homing it is the raw feedback
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			machine_pos_r <= AHS_POS_RST;
		end else if (homed_r) begin
			machine_pos_r <= pos_i - ref_pos_r + $signed(cfg_i.machine_zero_offset); // R14
		end else begin
			machine_pos_r <= pos_i;
		end
	end

	assign not_homed_motion_error_o = err_r;
	assign stat_o.homed             = homed_r;
	assign stat_o.busy              = (state_r != ST_IDLE);
	assign stat_o.grid_amount       = grid_amount_r;
	assign stat_o.machine_pos       = machine_pos_r;

	// ============================================================
	// checks
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_b_i);

	// helper: cycles spent braking; a full-scale speed at step 1 is the longest case
	localparam int DECEL_CYC_MAX = 2 ** SPD_W;

	logic [SPD_W+1:0] decel_cnt_r;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i || state_r != ST_DECEL) begin
			decel_cnt_r <= '0;
		end else begin
			decel_cnt_r <= decel_cnt_r + 1'b1;
		end
	end

	sequence s_decel_done;
		state_r == ST_DECEL && speed_o == AHS_SPD_RST;
	endsequence

	sequence s_approach_run;
		state_r == ST_APPROACH ##1 speed_o == sgn_spd(cfg_i.homing_approach_speed, cfg_i.dir_neg);
	endsequence

	AST_DOG_START: assert property ( // R1
		(take_home && !cfg_i.noref && !homed_r) |=> state_r == ST_RAPID)
		else $error("dog homing did not start");
	AST_DOG_DECEL: assert property ( // R2
		(state_r == ST_RAPID && dog_i) |=> state_r == ST_DECEL)
		else $error("dog deceleration sequence broken");
	AST_DECEL_BOUND: assert property ( // R2
		decel_cnt_r <= DECEL_CYC_MAX)
		else $error("deceleration never reached standstill");
	AST_APPROACH_STEP: assert property ( // R15
		s_decel_done |=> s_approach_run)
		else $error("approach speed not stepped in");
	AST_GRID_STOP: assert property ( // R3
		(state_r == ST_SEEK && grid_pt && cfg_i.home_shift_amount == '0) |=> homed_r && state_r == ST_IDLE ##1 speed_o == AHS_SPD_RST)
		else $error("no stop at grid point");
	AST_HS_RETURN: assert property ( // R5
		(take_home && !cfg_i.noref && homed_r && cfg_i.hs_return_en) |=> state_r == ST_POSN && tgt_r == $past(ref_pos_r))
		else $error("high-speed return not taken");
	AST_NOT_HOMED: assert property ( // R6
		(take_move && !homed_r && !cfg_i.noref) |=> not_homed_motion_error_o && state_r == ST_IDLE ##1 !not_homed_motion_error_o)
		else $error("motion before homing not refused");
	AST_MASK_HOLD: assert property ( // R9
		(state_r == ST_MASK && trav_w < cfg_i.grid_mask) |=> state_r == ST_MASK)
		else $error("grid taken inside mask");
	AST_NOREF_SKIP: assert property ( // R13
		(take_home && cfg_i.noref) |=> state_r == ST_IDLE && $stable(homed_r))
		else $error("homing ran with no-reference set");
	AST_MACH_POS: assert property ( // R14
		homed_r && $past(homed_r) |-> machine_pos_r == $past(pos_i) - $past(ref_pos_r) + $signed($past(cfg_i.machine_zero_offset)))
		else $error("machine position offset wrong");
	AST_HOMED_SET: assert property ( // R19
		(!homed_r && !home_done) |=> !homed_r)
		else $error("homed flag set without homing");
endmodule

// file: hdl/ahs_pkg.sv
package ahs_pkg;

	// ============================================================
	// widths
	localparam int POS_W = 32;
	localparam int SPD_W = 16;

	// ============================================================
	// reset values and direction codes
	localparam logic [POS_W-1:0] AHS_POS_RST = 32'h0000_0000;
	localparam logic [SPD_W:0]   AHS_SPD_RST = 17'h0_0000;
	localparam logic             AHS_DIR_POS = 1'b0;
	localparam logic             AHS_DIR_NEG = 1'b1;

	// ============================================================
	// approach speed guidance in mm/min, for whoever fills the config
	localparam int AHS_APPROACH_LOW_MM_MIN  = 100;
	localparam int AHS_APPROACH_HIGH_MM_MIN = 300;
	localparam int AHS_APPROACH_MAX_MM_MIN  = 500;

	// ============================================================
	// command kinds
	typedef enum logic {
		AHS_CMD_MOVE,
		AHS_CMD_HOME
	} ahs_cmd_kind_t;

	// axis settings, speeds are position units per clock, magnitudes
	typedef struct packed {
		logic [SPD_W-1:0] homing_rapid_rate;
		logic [SPD_W-1:0] rapid_rate;
		logic [SPD_W-1:0] homing_approach_speed;
		logic [SPD_W-1:0] decel_step;
		logic [POS_W-1:0] grid_space;
		logic [POS_W-1:0] screw_pitch;
		logic [POS_W-1:0] grid_mask;
		logic [POS_W-1:0] home_shift_amount;
		logic [POS_W-1:0] machine_zero_offset;
		logic             dir_neg;
		logic             noref;
		logic             hs_return_en;
	} ahs_cfg_t;

	typedef struct packed {
		ahs_cmd_kind_t    kind;
		logic             manual;
		logic [POS_W-1:0] target;
	} ahs_cmd_t;

	typedef struct packed {
		logic             homed;
		logic             busy;
		logic [POS_W-1:0] grid_amount;
		logic [POS_W-1:0] machine_pos;
	} ahs_stat_t;

endpackage

// file: hdl/ahs_ramp.sv
`timescale 1ns/10ps
// speed generator: ramps toward the target, or steps when jump_i is high
module ahs_ramp #(
	parameter int W = 17
) (
	input  wire logic                ref_clk_i,
	input  wire logic                rst_b_i,
	input  wire logic signed [W-1:0] target_i,
	input  wire logic        [W-2:0] step_i,
	input  wire logic                jump_i,
	output logic signed      [W-1:0] speed_o
);
	logic signed [W-1:0] step_s;
	logic signed [W-1:0] diff;

	assign step_s = $signed({1'b0, step_i});
	assign diff   = target_i - speed_o;

	// ============================================================
	// a zero step would freeze the axis, so it is treated as a jump
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			speed_o <= '0;
		end else if (jump_i || step_i == '0) begin
			speed_o <= target_i;
		end else if (diff > step_s) begin
			speed_o <= speed_o + step_s;
		end else if (diff < -step_s) begin
			speed_o <= speed_o - step_s;
		end else begin
			speed_o <= target_i;
		end
	end
endmodule

// file: hdl/ahs_grid.sv
`timescale 1ns/10ps
// grid point generator from the encoder index and travelled distance
module ahs_grid #(
	parameter int W = 32
) (
	input  wire logic                ref_clk_i,
	input  wire logic                rst_b_i,
	input  wire logic                index_i,
	input  wire logic signed [W-1:0] pos_i,
	input  wire logic        [W-1:0] grid_space_i,
	input  wire logic        [W-1:0] screw_pitch_i,
	output logic                     grid_o
);
	logic signed [W-1:0] prev_r;
	logic        [W-1:0] phase_r;
	logic        [W-1:0] phase_nxt;
	logic        [W-1:0] space;

	// zero spacing falls back to the screw pitch
	assign space     = (grid_space_i == '0) ? screw_pitch_i : grid_space_i; // R18
	assign phase_nxt = phase_r + ((pos_i >= prev_r) ? W'(pos_i - prev_r) : W'(prev_r - pos_i));

	// ============================================================
	// the index realigns the phase; between indexes points repeat every space
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			prev_r  <= '0;
			phase_r <= '0;
			grid_o  <= 1'b0;
		end else begin
			prev_r <= pos_i;
			if (index_i) begin
				phase_r <= '0; // R7
				grid_o  <= 1'b1; // R7
			end else if (space != '0 && phase_nxt >= space) begin
				phase_r <= phase_nxt - space; // R8
				grid_o  <= 1'b1; // R8
			end else begin
				phase_r <= phase_nxt;
				grid_o  <= 1'b0;
			end
		end
	end
endmodule

// file: dv/ahs_axis_model.sv
`timescale 1ns/10ps
// ============================================================
// axis plant: integrates the speed command, owns dog switch and encoder index
module ahs_axis_model
	import ahs_pkg::*;
#(
	parameter int REV    = 512,
	parameter int DOG_LO = 2000,
	parameter int DOG_HI = 3000
) (
	input  wire logic                          ref_clk_i,
	input  wire logic                          rst_b_i,
	input  wire logic signed [ahs_pkg::SPD_W:0] speed_i,
	output logic signed [ahs_pkg::POS_W-1:0]    pos_o,
	output logic                               dog_o,
	output logic                               index_o
);
	import ahs_pkg::*;

	logic signed [POS_W-1:0] mag;
	logic signed [POS_W-1:0] pos_nxt;

	// position integrates speed once per clock, sign extended
	assign pos_nxt = pos_o + {{(POS_W-SPD_W-1){speed_i[SPD_W]}}, speed_i};

	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			pos_o <= '0;
		end else begin
			pos_o <= pos_nxt;
		end
	end

	// dog mirrored about zero so both search directions meet one
	assign mag   = pos_o[POS_W-1] ? -pos_o : pos_o;
	assign dog_o = (mag >= DOG_LO) && (mag <= DOG_HI);

	// index pulses for one cycle together with the first position past a
	// revolution boundary, as a real encoder would, so grids sit on the boundary;
	// speeds stay far below one revolution per clock, so no pulse is lost
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			index_o <= 1'b0;
		end else begin
			index_o <= (pos_nxt >>> $clog2(REV)) != (pos_o >>> $clog2(REV));
		end
	end
endmodule

// file: dv/ahs_homing_seq_tb_top.sv
`timescale 1ns/10ps
module ahs_homing_seq_tb_top;
	import ahs_pkg::*;

	logic                    ref_clk_i = 1'b0;
	logic                    rst_b_i   = 1'b0;
	logic                    cmd_valid = 1'b0;
	ahs_cfg_t                cfg       = '0;
	ahs_cmd_t                cmd       = '0;
	logic                    cmd_ready;
	logic                    dog;
	logic                    index;
	logic                    err;
	logic signed [POS_W-1:0] pos;
	logic signed [SPD_W:0]   speed;
	ahs_stat_t               stat;
	logic        [15:0]      seed      = 16'hE2BA;
	int                      error_cnt = 0;
	int                      compares  = 0;
	logic signed [SPD_W:0]   peak;
	logic signed [POS_W-1:0] last_ref;
	logic                    step_seen;
	logic                    err_seen;
	logic                    dog_seen;

	initial forever #2.5 ref_clk_i = ~ref_clk_i;

	ahs_homing_seq ahs_homing_seq_inst (
		.ref_clk_i                (ref_clk_i),
		.rst_b_i                  (rst_b_i),
		.cfg_i                    (cfg),
		.cmd_valid_i              (cmd_valid),
		.cmd_i                    (cmd),
		.cmd_ready_o              (cmd_ready),
		.dog_i                    (dog),
		.index_i                  (index),
		.pos_i                    (pos),
		.speed_o                  (speed),
		.not_homed_motion_error_o (err),
		.stat_o                   (stat)
	);

	ahs_axis_model ahs_axis_model_inst (
		.ref_clk_i (ref_clk_i),
		.rst_b_i   (rst_b_i),
		.speed_i   (speed),
		.pos_o     (pos),
		.dog_o     (dog),
		.index_o   (index)
	);

	// ============================================================
	// helpers
	task automatic give_verdict();
		$display("checks %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic ok, input string msg);
		compares++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("ERROR %0t %s", $time, msg);
		end
	endtask

	// tolerance compare: stop points lag grid events by a few steps
	function automatic logic near(input logic signed [POS_W-1:0] a, input logic signed [POS_W-1:0] b, input int tol);
		logic signed [POS_W-1:0] d;
		d = a - b;
		return (d <= tol) && (d >= -tol);
	endfunction

	function automatic logic [15:0] rnd();
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		return seed;
	endfunction

	// first grid past dog end plus mask, 512 per turn when spacing is 0
	function automatic int exp_grid(input int gs, input int mask);
		int g;
		g = (gs == 0) ? 512 : gs;
		return ((3000 + mask) / g + 1) * g;
	endfunction

	function automatic ahs_cfg_t base_cfg();
		ahs_cfg_t c;
		c                       = '0;
		c.homing_rapid_rate     = 16'h0028;
		c.rapid_rate            = 16'h003C;
		c.homing_approach_speed = 16'h0006;
		c.decel_step            = 16'h0004;
		c.screw_pitch           = 32'h0000_0200;
		return c;
	endfunction

	task automatic do_reset(input ahs_cfg_t c);
		@(posedge ref_clk_i);
		rst_b_i <= 1'b0;
		cfg     <= c;
		repeat (6) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		#1 chk(stat.homed === 1'b0 && stat.busy === 1'b0 && cmd_ready === 1'b1 && speed === '0, "reset state");
	endtask

	task automatic send(input ahs_cmd_kind_t k, input logic signed [POS_W-1:0] t);
		void'(rnd());
		@(posedge ref_clk_i);
		cmd_valid   <= 1'b1;
		cmd.kind    <= k;
		cmd.manual  <= seed[0];
		cmd.target  <= t;
		@(posedge ref_clk_i);
		cmd_valid   <= 1'b0;
	endtask

	// follows one command to idle, noting pre-dog peak and the approach step
	task automatic run(input logic signed [SPD_W:0] appr);
		logic signed [SPD_W:0] prev;
		peak      = '0;
		prev      = '0;
		step_seen = 1'b0;
		err_seen  = 1'b0;
		dog_seen  = 1'b0;
		for (int n = 0; n < 8000; n++) begin
			#1;
			if (err === 1'b1) err_seen = 1'b1;
			if (dog === 1'b1) dog_seen = 1'b1;
			if (!dog_seen && (speed > 0 ? speed > peak : speed < peak)) peak = speed;
			if (dog_seen && prev === '0 && speed === appr) step_seen = 1'b1;
			prev = speed;
			if (n > 1 && stat.busy === 1'b0) break;
			@(posedge ref_clk_i);
		end
		repeat (3) @(posedge ref_clk_i);
		#1;
		// a command still running here ran out of the loop limit
		if (stat.busy !== 1'b0) begin
			error_cnt++;
			$display("ERROR %0t command did not finish", $time);
		end
	endtask

	// ============================================================
	// dog homing after power-up, refused move first
	task automatic home_case(input logic dir, input int shift, input int mask, input int gs);
		ahs_cfg_t                c;
		logic signed [POS_W-1:0] off;
		int                      sgn;
		int                      g;
		c                     = base_cfg();
		off                   = {rnd(), rnd()};
		c.dir_neg             = dir;
		c.home_shift_amount   = shift;
		c.grid_mask           = mask;
		c.grid_space          = gs;
		c.machine_zero_offset = off;
		sgn                   = dir ? -1 : 1;
		g                     = exp_grid(gs, mask);
		last_ref              = sgn * (g + shift);
		do_reset(c);
		send(AHS_CMD_MOVE, 32'sh0000_0400);
		run('0);
		chk(err_seen === 1'b1 && pos === '0 && stat.homed === 1'b0, "move before homing");
		send(AHS_CMD_HOME, '0);
		run((SPD_W+1)'(sgn * 6));
		chk(peak === (SPD_W+1)'(sgn * 40), "homing rapid rate");
		chk(step_seen, "approach speed step after stop");
		chk(stat.homed === 1'b1 && near(pos, last_ref, 32), "stop at reference");
		chk(near(stat.grid_amount, g - 3000 - mask, 16), "grid amount");
		chk(near(stat.machine_pos, pos - last_ref + off, 32), "machine position");
		$display("test home dir %0d shift %0d mask %0d space %0d done", dir, shift, mask, gs);
	endtask

	initial begin
		ahs_cfg_t c;
		home_case(1'b0, 0, 0, 0);
		home_case(1'b1, rnd() % 256, 0, 0);
		home_case(1'b0, 0, 100, 0);
		home_case(1'b0, rnd() % 64, 100, 256);
		// later homing with fast return selected
		@(posedge ref_clk_i);
		cfg.hs_return_en <= 1'b1;
		send(AHS_CMD_MOVE, '0);
		run('0);
		chk(err_seen === 1'b0 && near(pos, '0, 300), "move once homed");
		send(AHS_CMD_HOME, '0);
		run((SPD_W+1)'(6));
		chk(peak === (SPD_W+1)'(60) && !step_seen && near(pos, last_ref, 300), "high-speed return");
		$display("test high-speed return done");
		// fast return switched off again: a later homing searches the dog once more
		@(posedge ref_clk_i);
		cfg.hs_return_en <= 1'b0;
		send(AHS_CMD_MOVE, '0);
		run('0);
		send(AHS_CMD_HOME, '0);
		run((SPD_W+1)'(6));
		chk(step_seen && stat.homed === 1'b1 && near(pos, last_ref, 32), "dog homing once homed");
		$display("test repeated dog homing done");
		// axis without reference moves freely
		c       = base_cfg();
		c.noref = 1'b1;
		do_reset(c);
		send(AHS_CMD_MOVE, 32'sh0000_0400);
		run('0);
		chk(err_seen === 1'b0 && near(pos, 32'sh0000_0400, 300), "no-reference move");
		send(AHS_CMD_HOME, '0);
		run('0);
		chk(stat.homed === 1'b0 && near(pos, 32'sh0000_0400, 300), "no-reference home ignored");
		$display("test no-reference done");
		give_verdict();
	end

	// watchdog: whole run is a few thousand cycles
	initial begin
		#200000;
		error_cnt++;
		$display("ERROR %0t watchdog expired", $time);
		give_verdict();
	end
endmodule
